// [rtl/wdt_pkg.sv]
package wdt_pkg;

  // register bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [15:0] PMODE1_ADDR = 16'h0005;
  localparam logic [15:0] CLKMODE1_ADDR = 16'h0007;
  localparam logic [15:0] REFRESH_ADDR = 16'h000d;
  localparam logic [15:0] START_ADDR = 16'h000e;
  localparam logic [15:0] WDCTRL_ADDR = 16'h000f;
  localparam logic [15:0] CLKPROT_ADDR = 16'h001c;
  localparam logic [15:0] IRQ_STATUS_ADDR = 16'h0020;
  localparam logic [15:0] IRQ_MASK_ADDR = 16'h0021;
  localparam logic [15:0] COUNT_LO_ADDR = 16'h0022;
  localparam logic [15:0] COUNT_HI_ADDR = 16'h0023;
  localparam logic [15:0] OPTION_ADDR = 16'hffff;

  // field positions
  localparam int RATIO_SEL_BIT = 7;
  localparam int ACTION_SEL_BIT = 2;
  localparam int STOP_ENTRY_BIT = 0;
  localparam int OSC_STOP_BIT = 4;
  localparam int PROTECT_EN_BIT = 7;
  localparam int OPT_AUTO_START_BIT = 0;
  localparam int OPT_PROTECT_INIT_BIT = 7;
  localparam int IRQ_UNDERFLOW_BIT = 0;

  // refresh sequence bytes
  localparam logic [7:0] REFRESH_FIRST = 8'h00;
  localparam logic [7:0] REFRESH_SECOND = 8'hff;

  // timing counts
  localparam int PRE_DIV_FAST = 16;
  localparam int PRE_DIV_SLOW = 128;
  localparam int COUNT_FULL = 32768;
  localparam int PROTECT_COUNT = 4096;

  // reset values
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_type;

  // run state
  typedef enum logic [1:0] {
    ST_BOOT = 2'b00,
    ST_HALT = 2'b01,
    ST_COUNT = 2'b11
  } wd_state_type;

  // whole state of the watchdog
  typedef struct packed {
    wd_state_type state;
    logic [7:0] option;
    logic [6:0] prescale;
    logic [14:0] count;
    logic armed;
    logic ratio_sel;
    logic action_sel;
    logic protect;
    logic stop_entry;
    logic osc_stop;
    logic irq_status;
    logic irq_mask;
    logic [7:0] rdata;
    logic wd_reset;
  } wd_regs_type;

endpackage

// [rtl/watchdog_timer.sv]
// Summary of operation
// R01: unprotected, the prescaler runs from the cpu clock.
// R02: the count of 32768 drops once per prescaler tick, so the period is ratio times 32768 cpu clocks.
// R03: one select bit picks a prescaler ratio of 16 or 128.
// R04: writing 00h then ffh to the refresh register, in that order, reloads the count.
// R05: reset and every underflow also reload the count.
// R06: with the auto-start option at 1 the watchdog waits after reset until the start register is written.
// R07: with the auto-start option at 0 the watchdog counts as soon as reset ends.
// R08: the auto-start option is bit 0 of the read-only option byte at ffffh, which program writes cannot change.
// R09: unprotected, the count holds in stop and wait modes and resumes from where it stood.
// R10: with the underflow action bit at 0 an underflow raises the watchdog interrupt.
// R11: with the underflow action bit at 1 an underflow raises the watchdog reset.
// R12: only reset clears the prescaler, so a refresh leaves it running.
// R13: protected, the count runs from the slow oscillator even while the cpu clock halts.
// R14: protected, a count of 4096 oscillator ticks is used with no prescaler.
// R15: enabling protection loads 0fffh, forces the oscillator on and forces the reset action.
// R16: protected, writes to the stop-mode entry and oscillator-stop bits are ignored.
// R17: refresh, reset and underflow reload the full-scale start value of the current mode.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps

module watchdog_timer
  #(
    parameter int unsigned PRE_FAST = wdt_pkg::PRE_DIV_FAST,
    parameter int unsigned PRE_SLOW = wdt_pkg::PRE_DIV_SLOW,
    parameter int unsigned COUNT_TOP = wdt_pkg::COUNT_FULL,
    parameter int unsigned PROT_TOP = wdt_pkg::PROTECT_COUNT
  )
  (
    input wire logic clock_in, // cpu clock
    input wire logic arst_n_in, // async reset, active low
    input wire wdt_pkg::bus_req_type bus_in, // register request
    input wire logic [7:0] option_byte_in, // nonvolatile option byte
    input wire logic cpu_halt_in, // cpu clock stopped
    input wire logic wait_mode_in, // cpu in wait mode
    input wire logic wake_in, // stop mode exit event
    input wire logic slow_osc_tick_in, // slow oscillator enable pulse
    output logic [7:0] rdata_out, // read data, one cycle after read
    output logic irq_out, // watchdog interrupt level
    output logic wd_reset_out, // watchdog reset pulse
    output logic stop_mode_out, // stop mode requested
    output logic slow_osc_stop_out // slow oscillator off
  );

  import wdt_pkg::*;

  localparam logic [6:0] PRE_LAST_FAST = 7'(PRE_FAST - 1);
  localparam logic [6:0] PRE_LAST_SLOW = 7'(PRE_SLOW - 1);
  localparam logic [14:0] RELOAD_FULL = 15'(COUNT_TOP - 1);
  localparam logic [14:0] RELOAD_PROT = 15'(PROT_TOP - 1);

  localparam wd_regs_type REGS_RESET = '{
    state: ST_BOOT,
    option: OPTION_RESET,
    prescale: 7'h00,
    count: RELOAD_FULL,
    armed: 1'b0,
    ratio_sel: 1'b0,
    action_sel: 1'b0,
    protect: 1'b0,
    stop_entry: 1'b0,
    osc_stop: 1'b0,
    irq_status: 1'b0,
    irq_mask: 1'b0,
    rdata: BYTE_ZERO,
    wd_reset: 1'b0
  };

  wd_regs_type state_reg;
  wd_regs_type state_next;
  logic wr_refresh;
  logic wr_start;
  logic wr_ctrl;
  logic wr_pmode;
  logic wr_clkmode;
  logic wr_prot;
  logic wr_status;
  logic wr_mask;
  logic freeze;
  logic pre_step;
  logic [6:0] pre_last;
  logic pre_wrap;
  logic count_tick;
  logic underflow;
  logic refresh_fire;
  logic prot_enable;
  logic [14:0] reload_val;
  logic [7:0] rd_mux;

  // write decode
  assign wr_refresh = bus_in.wr && (bus_in.addr == REFRESH_ADDR);
  assign wr_start = bus_in.wr && (bus_in.addr == START_ADDR);
  assign wr_ctrl = bus_in.wr && (bus_in.addr == WDCTRL_ADDR);
  assign wr_pmode = bus_in.wr && (bus_in.addr == PMODE1_ADDR);
  assign wr_clkmode = bus_in.wr && (bus_in.addr == CLKMODE1_ADDR);
  assign wr_prot = bus_in.wr && (bus_in.addr == CLKPROT_ADDR);
  assign wr_status = bus_in.wr && (bus_in.addr == IRQ_STATUS_ADDR);
  assign wr_mask = bus_in.wr && (bus_in.addr == IRQ_MASK_ADDR);

  // count sources and ticks
  assign freeze = !state_reg.protect && (wait_mode_in || state_reg.stop_entry); // [R09]
  assign pre_step = (state_reg.state == ST_COUNT) && !state_reg.protect && !freeze && !cpu_halt_in; // [R01]
  assign pre_last = state_reg.ratio_sel ? PRE_LAST_SLOW : PRE_LAST_FAST; // [R03]
  assign pre_wrap = pre_step && (state_reg.prescale >= pre_last);
  assign count_tick = state_reg.protect ? ((state_reg.state == ST_COUNT) && slow_osc_tick_in) // [R13] [R14]
                                        : pre_wrap; // [R02]
  assign underflow = count_tick && (state_reg.count == 15'h0000);
  assign refresh_fire = wr_refresh && state_reg.armed && (bus_in.wdata == REFRESH_SECOND); // [R04]
  assign prot_enable = wr_prot && bus_in.wdata[PROTECT_EN_BIT] && !state_reg.protect;
  assign reload_val = state_reg.protect ? RELOAD_PROT : RELOAD_FULL; // [R17]

  // read multiplexer
  always_comb
  begin
    rd_mux = BYTE_ZERO;
    unique case (bus_in.addr)
      WDCTRL_ADDR: rd_mux[RATIO_SEL_BIT] = state_reg.ratio_sel;
      PMODE1_ADDR: rd_mux[ACTION_SEL_BIT] = state_reg.action_sel;
      CLKMODE1_ADDR:
      begin
        rd_mux[STOP_ENTRY_BIT] = state_reg.stop_entry;
        rd_mux[OSC_STOP_BIT] = state_reg.osc_stop;
      end
      CLKPROT_ADDR: rd_mux[PROTECT_EN_BIT] = state_reg.protect;
      IRQ_STATUS_ADDR: rd_mux[IRQ_UNDERFLOW_BIT] = state_reg.irq_status;
      IRQ_MASK_ADDR: rd_mux[IRQ_UNDERFLOW_BIT] = state_reg.irq_mask;
      COUNT_LO_ADDR: rd_mux = state_reg.count[7:0];
      COUNT_HI_ADDR: rd_mux = {1'b0, state_reg.count[14:8]};
      OPTION_ADDR: rd_mux = state_reg.option; // [R08]
      default: rd_mux = BYTE_ZERO;
    endcase
  end

  // next state of the whole block
  always_comb
  begin
    state_next = state_reg;
    state_next.wd_reset = 1'b0;
    state_next.rdata = bus_in.rd ? rd_mux : BYTE_ZERO;

    // option byte caught once after reset release, start mode from it
    unique case (state_reg.state)
      ST_BOOT:
      begin
        state_next.option = option_byte_in; // [R08]
        state_next.protect = !option_byte_in[OPT_PROTECT_INIT_BIT];
        state_next.action_sel = !option_byte_in[OPT_PROTECT_INIT_BIT];
        state_next.count = option_byte_in[OPT_PROTECT_INIT_BIT] ? RELOAD_FULL : RELOAD_PROT;
        state_next.state = option_byte_in[OPT_AUTO_START_BIT] ? ST_HALT : ST_COUNT; // [R06] [R07]
      end
      ST_HALT:
      begin
        if (wr_start)
        begin
          state_next.state = ST_COUNT; // [R06]
        end
      end
      ST_COUNT: state_next.state = ST_COUNT;
      default: state_next.state = ST_BOOT;
    endcase

    // prescaler, cleared only by reset
    if (pre_step)
    begin
      state_next.prescale = pre_wrap ? 7'h00 : 7'(state_reg.prescale + 7'h01); // [R12]
    end

    // count down, reload on underflow
    if (underflow)
    begin
      state_next.count = reload_val; // [R05] [R17]
      if (state_reg.action_sel)
      begin
        state_next.wd_reset = 1'b1; // [R11]
      end
    end
    else if (count_tick)
    begin
      state_next.count = 15'(state_reg.count - 15'h0001); // [R02]
    end

    // two-write refresh sequence
    if (wr_refresh)
    begin
      state_next.armed = (bus_in.wdata == REFRESH_FIRST); // [R04]
      if (refresh_fire)
      begin
        state_next.count = reload_val; // [R04] [R17]
      end
    end

    // control bits
    if (wr_ctrl)
    begin
      state_next.ratio_sel = bus_in.wdata[RATIO_SEL_BIT]; // [R03]
    end
    if (wr_pmode && !state_reg.protect)
    begin
      state_next.action_sel = bus_in.wdata[ACTION_SEL_BIT];
    end
    if (wr_clkmode && !state_reg.protect)
    begin
      state_next.stop_entry = bus_in.wdata[STOP_ENTRY_BIT]; // [R16]
      state_next.osc_stop = bus_in.wdata[OSC_STOP_BIT]; // [R16]
    end
    if (wake_in)
    begin
      state_next.stop_entry = 1'b0;
    end

    // protection enable is sticky until reset
    if (prot_enable)
    begin
      state_next.protect = 1'b1;
      state_next.count = RELOAD_PROT; // [R15]
      state_next.osc_stop = 1'b0; // [R15]
      state_next.action_sel = 1'b1; // [R15]
      state_next.stop_entry = 1'b0;
    end

    // interrupt status, set wins over clear
    if (wr_status && bus_in.wdata[IRQ_UNDERFLOW_BIT])
    begin
      state_next.irq_status = 1'b0;
    end
    if (underflow && !state_reg.action_sel)
    begin
      state_next.irq_status = 1'b1; // [R10]
    end
    if (wr_mask)
    begin
      state_next.irq_mask = bus_in.wdata[IRQ_UNDERFLOW_BIT];
    end
  end

  // state register
  always_ff @(posedge clock_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      state_reg <= REGS_RESET; // [R05] [R12]
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign rdata_out = state_reg.rdata;
  assign irq_out = state_reg.irq_status && state_reg.irq_mask;
  assign wd_reset_out = state_reg.wd_reset;
  assign stop_mode_out = state_reg.stop_entry;
  assign slow_osc_stop_out = state_reg.osc_stop;

  // checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!arst_n_in);

  property p_pre_wrap;
    pre_step && !state_reg.ratio_sel && (state_reg.prescale == PRE_LAST_FAST) |=> (state_reg.prescale == 7'h00);
  endproperty
  a_pre_wrap: assert property (p_pre_wrap) else $error("prescaler did not wrap at 16"); // [R03]

  property p_pre_frozen;
    (state_reg.state == ST_COUNT) && !state_reg.protect && (freeze || cpu_halt_in) |=> $stable(state_reg.prescale);
  endproperty
  a_pre_frozen: assert property (p_pre_frozen) else $error("prescaler moved while frozen"); // [R01]

  property p_count_step;
    count_tick && (state_reg.count != 15'h0000) && !wr_refresh && !prot_enable
      |=> (state_reg.count == $past(state_reg.count) - 15'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count did not step down"); // [R02]

  property p_refresh;
    refresh_fire && !prot_enable |=> (state_reg.count == $past(reload_val));
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh did not reload"); // [R04]

  property p_no_lone_refresh;
    wr_refresh && !state_reg.armed && !count_tick && !prot_enable |=> $stable(state_reg.count);
  endproperty
  a_no_lone_refresh: assert property (p_no_lone_refresh) else $error("unarmed write reloaded count"); // [R04]

  property p_underflow_irq;
    underflow && !state_reg.action_sel |=> state_reg.irq_status && !wd_reset_out;
  endproperty
  a_underflow_irq: assert property (p_underflow_irq) else $error("underflow gave no interrupt"); // [R10]

  property p_underflow_reset;
    underflow && state_reg.action_sel |=> wd_reset_out ##1 !wd_reset_out;
  endproperty
  a_underflow_reset: assert property (p_underflow_reset) else $error("underflow gave no reset pulse"); // [R11]

  property p_frozen_count;
    (state_reg.state == ST_COUNT) && freeze && !bus_in.wr |=> $stable(state_reg.count);
  endproperty
  a_frozen_count: assert property (p_frozen_count) else $error("count moved in stop or wait"); // [R09]

  property p_halted;
    ((state_reg.state == ST_HALT) && !wr_start) [*2] |-> $stable(state_reg.prescale);
  endproperty
  a_halted: assert property (p_halted) else $error("prescaler ran before start"); // [R06]

  property p_protect_load;
    prot_enable |=> (state_reg.count == RELOAD_PROT) && state_reg.action_sel && !state_reg.osc_stop;
  endproperty
  a_protect_load: assert property (p_protect_load) else $error("protect enable load wrong"); // [R15]

  property p_protect_locks;
    state_reg.protect && wr_clkmode && !wake_in |=> $stable(state_reg.stop_entry) && $stable(state_reg.osc_stop);
  endproperty
  a_protect_locks: assert property (p_protect_locks) else $error("clock mode bits changed"); // [R16]

  property p_protect_tick;
    state_reg.protect && (state_reg.state == ST_COUNT) && !slow_osc_tick_in && !bus_in.wr |=> $stable(state_reg.count);
  endproperty
  a_protect_tick: assert property (p_protect_tick) else $error("count moved without osc tick"); // [R13]

  property p_option_ro;
    (state_reg.state != ST_BOOT) |=> $stable(state_reg.option);
  endproperty
  a_option_ro: assert property (p_option_ro) else $error("option byte changed"); // [R08]

  // start write, refresh and wake side effects
  property p_halt_start;
    (state_reg.state == ST_HALT) && wr_start |=> (state_reg.state == ST_COUNT);
  endproperty
  a_halt_start: assert property (p_halt_start) else $error("start write did not start count"); // [R06]

  property p_prescale_kept;
    refresh_fire && pre_step && !pre_wrap |=> (state_reg.prescale == $past(state_reg.prescale) + 7'h01);
  endproperty
  a_prescale_kept: assert property (p_prescale_kept) else $error("refresh disturbed the prescaler"); // [R12]

  property p_wake_clears;
    wake_in |=> !state_reg.stop_entry;
  endproperty
  a_wake_clears: assert property (p_wake_clears) else $error("wake left stop bit set"); // [R09]

  c_irq: cover property (underflow && !state_reg.action_sel);
  c_reset: cover property (underflow && state_reg.action_sel);
  c_refresh: cover property (refresh_fire);
  c_protect: cover property (prot_enable);
  c_start: cover property ((state_reg.state == ST_HALT) && wr_start);

endmodule

// [verification/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import wdt_pkg::*;
  localparam int CT = 64;
  localparam int PT = 32;
  localparam int TK = 8;
  logic clock_in, arst_n_in, cpu_halt_in, wait_mode_in, wake_in, slow_osc_tick_in, tick_en;
  bus_req_type bus_in;
  logic [7:0] option_byte_in, rdata_out, b;
  logic irq_out, wd_reset_out, stop_mode_out, slow_osc_stop_out, rd_pend, rst_prev;
  logic [7:0] exp_q[$];
  int fails, total_checks, seed, cyc, n;

  watchdog_timer #(.PRE_FAST(PRE_DIV_FAST), .PRE_SLOW(PRE_DIV_SLOW), .COUNT_TOP(CT), .PROT_TOP(PT)) DUT (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .bus_in(bus_in), .option_byte_in(option_byte_in),
    .cpu_halt_in(cpu_halt_in), .wait_mode_in(wait_mode_in), .wake_in(wake_in),
    .slow_osc_tick_in(slow_osc_tick_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .wd_reset_out(wd_reset_out), .stop_mode_out(stop_mode_out), .slow_osc_stop_out(slow_osc_stop_out));

  // cpu clock
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  // slow oscillator pulse every TK cycles while enabled
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    slow_osc_tick_in <= tick_en && (cyc % TK == 0);
  end

  task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // read answers are taken off the queue the cycle after the strobe
  always @(negedge clock_in)
  begin
    if (rd_pend === 1'b1)
    begin
      if (exp_q.size() == 0) cmp("read queue", 8'h00, 8'hee);
      else cmp("read data", exp_q.pop_front(), rdata_out);
    end
    rd_pend = bus_in.rd;
    if (rst_prev === 1'b1) cmp("reset pulse width", 8'h00, {7'h00, wd_reset_out});
    rst_prev = wd_reset_out;
  end

  task results;
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    bus_in <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock_in);
    bus_in <= '0;
  endtask

  task rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clock_in);
    bus_in <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge clock_in);
    bus_in <= '0;
  endtask

  task refresh;
    wr(REFRESH_ADDR, REFRESH_FIRST);
    wr(REFRESH_ADDR, REFRESH_SECOND);
  endtask

  // cycles until irq (sel 0) or watchdog reset (sel 1), bounded
  task measure(input bit sel, input int lo, input int hi, input string nm);
    n = 0;
    while (n < hi + 50 && (sel ? wd_reset_out : irq_out) !== 1'b1)
    begin
      @(negedge clock_in);
      n++;
    end
    total_checks++;
    if (n < lo || n > hi)
    begin
      fails++;
      $display("CHECK FAILED %s expected %0d to %0d seen %0d", nm, lo, hi, n);
    end
  endtask

  task do_reset(input logic [7:0] opt);
    @(posedge clock_in);
    arst_n_in <= 1'b0;
    option_byte_in <= opt;
    repeat (5) @(posedge clock_in);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clock_in);
  endtask

  task irq_clear;
    wr(IRQ_STATUS_ADDR, 8'h01);
  endtask

  // hang guard
  initial
  begin
    #600000;
    fails++;
    results();
  end

  initial
  begin
    seed = 90;
    cyc = 0;
    arst_n_in = 1'b0;
    bus_in = '0;
    option_byte_in = 8'hfe;
    cpu_halt_in = 1'b0;
    wait_mode_in = 1'b0;
    wake_in = 1'b0;
    tick_en = 1'b0;
    slow_osc_tick_in = 1'b0;
    // auto start, option byte read-only, unmapped read
    do_reset(8'hfe);
    rd(OPTION_ADDR, 8'hfe);
    wr(OPTION_ADDR, 8'h00);
    rd(OPTION_ADDR, 8'hfe);
    rd(16'h0100, 8'h00);
    wr(IRQ_MASK_ADDR, 8'h01);
    refresh();
    measure(0, 16 * 63, 16 * 64 + 3, "timeout div16");
    rd(IRQ_STATUS_ADDR, 8'h01);
    wr(IRQ_MASK_ADDR, 8'h00);
    @(negedge clock_in);
    cmp("masked irq", 8'h00, {7'h00, irq_out});
    wr(IRQ_MASK_ADDR, 8'h01);
    @(negedge clock_in);
    cmp("unmasked irq", 8'h01, {7'h00, irq_out});
    irq_clear();
    @(negedge clock_in);
    cmp("cleared irq", 8'h00, {7'h00, irq_out});
    rd(IRQ_STATUS_ADDR, 8'h00);
    // broken refresh pair must not reload
    refresh();
    repeat (600) @(posedge clock_in);
    b = 8'($random(seed));
    if (b == 8'h00 || b == 8'hff) b = 8'h5a;
    wr(REFRESH_ADDR, 8'h00);
    wr(REFRESH_ADDR, b);
    wr(REFRESH_ADDR, 8'hff);
    measure(0, 16 * 63 - 610, 16 * 64 - 600, "broken refresh");
    irq_clear();
    // proper refresh mid-count restarts full period
    refresh();
    repeat (600) @(posedge clock_in);
    refresh();
    measure(0, 16 * 63, 16 * 64 + 3, "refresh reload");
    irq_clear();
    // wait mode and halted cpu clock freeze the count
    refresh();
    wait_mode_in <= 1'b1;
    repeat (300) @(posedge clock_in);
    wait_mode_in <= 1'b0;
    cpu_halt_in <= 1'b1;
    repeat (300) @(posedge clock_in);
    cpu_halt_in <= 1'b0;
    measure(0, 16 * 62, 16 * 64 + 3, "frozen count");
    irq_clear();
    // slow prescaler
    wr(WDCTRL_ADDR, 8'h80);
    refresh();
    measure(0, 128 * 63, 128 * 64 + 3, "timeout div128");
    irq_clear();
    // reset action, then reload on underflow
    wr(PMODE1_ADDR, 8'h04);
    wr(WDCTRL_ADDR, 8'h00);
    refresh();
    measure(1, 16 * 63, 16 * 64 + 3, "reset action");
    @(negedge clock_in);
    measure(1, 16 * 63 - 4, 16 * 64 + 3, "underflow reload");
    rd(IRQ_STATUS_ADDR, 8'h00);
    // stop and oscillator bits writable when unprotected
    wr(CLKMODE1_ADDR, 8'h11);
    @(negedge clock_in);
    cmp("stop bit", 8'h01, {7'h00, stop_mode_out});
    cmp("osc stop bit", 8'h01, {7'h00, slow_osc_stop_out});
    @(posedge clock_in);
    wake_in <= 1'b1;
    @(posedge clock_in);
    wake_in <= 1'b0;
    @(negedge clock_in);
    cmp("stop after wake", 8'h00, {7'h00, stop_mode_out});
    // protection switched on at run time, slow ticks off so the count holds
    wr(PMODE1_ADDR, 8'h00);
    wr(CLKPROT_ADDR, 8'h80);
    @(negedge clock_in);
    cmp("forced osc on", 8'h00, {7'h00, slow_osc_stop_out});
    rd(COUNT_LO_ADDR, 8'(PT - 1));
    rd(PMODE1_ADDR, 8'h04);
    rd(CLKPROT_ADDR, 8'h80);
    // halted after reset until start write
    do_reset(8'hff);
    repeat (2000) @(posedge clock_in);
    rd(IRQ_STATUS_ADDR, 8'h00);
    rd(COUNT_LO_ADDR, 8'h3f);
    rd(COUNT_HI_ADDR, 8'h00);
    wr(IRQ_MASK_ADDR, 8'h01);
    wr(START_ADDR, 8'h00);
    measure(0, 16 * 63, 16 * 64 + 3, "start write");
    // protected at boot: slow clock, forced reset action, bits locked
    do_reset(8'h7e);
    tick_en <= 1'b1;
    cpu_halt_in <= 1'b1;
    wait_mode_in <= 1'b1;
    wr(CLKMODE1_ADDR, 8'h11);
    @(negedge clock_in);
    cmp("locked stop bit", 8'h00, {7'h00, stop_mode_out});
    cmp("locked osc bit", 8'h00, {7'h00, slow_osc_stop_out});
    rd(CLKMODE1_ADDR, 8'h00);
    rd(PMODE1_ADDR, 8'h04);
    measure(1, TK * PT - 40, TK * PT + 8, "protected timeout");
    results();
  end
endmodule
